//--- tmr_consts.svh
`ifndef TMR_CONSTS_SVH
`define TMR_CONSTS_SVH

// Register byte offsets inside the timer block.
`define TMR_OFF_TS      12'h000
`define TMR_OFF_GP0     12'h004
`define TMR_OFF_GP0_RL  12'h008
`define TMR_OFF_GP1     12'h00C
`define TMR_OFF_GP1_RL  12'h010
`define TMR_OFF_WDOG    12'h014
`define TMR_OFF_WDOG_EN 12'h018
`define TMR_OFF_KEY     12'h01C
`define TMR_OFF_STS     12'h020

// Field positions of the watchdog enable register.
`define TMR_WEN_CNT  0
`define TMR_WEN_IRQ  1
`define TMR_WEN_RST  2

// Field positions of the general-purpose reload register.
`define TMR_GP_EN    0
`define TMR_GP_ONE   1

// Field positions of the status register.
`define TMR_STS_GP0  0
`define TMR_STS_GP1  1
`define TMR_STS_TS   2
`define TMR_STS_WDOG 3
`define TMR_STS_WARM 4

// Unlock value of the key register and reset values.
`define TMR_KEY_VALUE  16'h482E
`define TMR_WDOG_RST   32'hFFFFFFFF
`define TMR_ZERO32     32'h00000000

// Timer tick: system clock in kHz over timer clock in kHz, rounded down.
`define TMR_SYS_KHZ    200000
`define TMR_TICK_KHZ   66660
`define TMR_TICK_DIV   (`TMR_SYS_KHZ / `TMR_TICK_KHZ)

`endif

//--- tmr_pkg.sv
package tmr_pkg;
  // One register word of the timer block.
  typedef logic [31:0] tmr_word_t;
  // Reload field of a general-purpose timer.
  typedef logic [29:0] tmr_rl_t;
  // Status vector, one bit per event source.
  typedef logic [4:0]  tmr_sts_t;
endpackage : tmr_pkg

//--- tmr_gp.sv
`timescale 1ns/100ps
`include "tmr_consts.svh"

// One general-purpose down counter with 30-bit reload and one-shot mode.
module tmr_gp (
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic              srst,
  input  wire logic              tick,
  input  wire logic              wr_rl,
  input  wire tmr_pkg::tmr_word_t wdata,
  output tmr_pkg::tmr_word_t     cnt,
  output tmr_pkg::tmr_word_t     ctrl,
  output logic                   fire
);

  tmr_pkg::tmr_word_t cnt_reg;   // Down counter.
  tmr_pkg::tmr_rl_t   rl_reg;    // Reload value, upper 30 counter bits.
  logic               en_reg;    // Count enable.
  logic               one_reg;   // One-shot control.

  // Zero is reached on a tick while counting; the counter then reloads.
  assign fire = tick & en_reg & (cnt_reg == `TMR_ZERO32);
  assign cnt  = cnt_reg;
  assign ctrl = {rl_reg, one_reg, en_reg};

  // Counter, reload and control; a reload write wins over counting.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= `TMR_ZERO32;
      rl_reg  <= 30'h0;
      en_reg  <= 1'b0;
      one_reg <= 1'b0;
    end else if (srst) begin
      cnt_reg <= `TMR_ZERO32;
      rl_reg  <= 30'h0;
      en_reg  <= 1'b0;
      one_reg <= 1'b0;
    end else if (wr_rl) begin
      // The counter is loaded at once, low two bits zero.
      rl_reg  <= wdata[31:2];
      one_reg <= wdata[`TMR_GP_ONE];
      en_reg  <= wdata[`TMR_GP_EN];
      cnt_reg <= {wdata[31:2], 2'b00};
    end else if (fire) begin
      cnt_reg <= {rl_reg, 2'b00};
      // A one-shot timer stops itself until software enables it again.
      if (one_reg) begin
        en_reg <= 1'b0;
      end
    end else if (tick && en_reg) begin
      cnt_reg <= cnt_reg - 32'h00000001;
    end
  end

  // A reload write leaves the two low counter bits clear.
  AST_GP_LOW_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (wr_rl && !srst) |=> (cnt_reg[1:0] == 2'b00 && cnt_reg[31:2] == $past(wdata[31:2])))
    else $error("Reload write did not load the counter.");

  // A one-shot expiry clears the enable and reloads.
  AST_GP_ONESHOT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (fire && one_reg && !wr_rl && !srst) |=> (!en_reg && cnt_reg == {rl_reg, 2'b00}))
    else $error("One-shot timer kept counting.");

  // A disabled timer holds its count.
  AST_GP_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!en_reg && !wr_rl && !srst) |=> $stable(cnt_reg))
    else $error("Disabled timer changed its count.");

endmodule : tmr_gp

//--- tmr_top.sv
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`include "tmr_consts.svh"

// Operation
// - Key register writable at any time.
// - Watchdog writes only when key unlocks.
// - Watchdog enable holds count, irq, reset.
// - Watchdog counts down only while enabled.
// - Watchdog zero raises irq when enabled.
// - Writing one clears the watchdog irq.
// - Watchdog zero with reset enable resets chip.
// - Warm bit survives watchdog reset; W1C.
// - Reset leaves all watchdog enables off.
// - Reset loads watchdog counter with ones.
// - Status register is five bits wide.
// - Time-stamp clears on reset, then counts.
// - Time-stamp wraps to zero and continues.
// - Time-stamp interrupt latched, cleared by one.
// - Reload fills upper thirty counter bits.
// - Reload write loads counter immediately.
// - Timer counts only while enabled.
// - Periodic mode reloads, interrupts, keeps counting.
// - One-shot mode reloads, interrupts, then stops.
// - Each timer has own irq and bit.
// - Reset clears timers and disables them.
// - Word accesses; reserved bits read zero.
// - Timers advance on the timer clock tick.
module tmr_top (
  input  wire logic              clk_sys,
  input  wire logic              nrst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire tmr_pkg::tmr_word_t pwdata,
  output tmr_pkg::tmr_word_t     prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   irq_gp0,
  output logic                   irq_gp1,
  output logic                   irq_ts,
  output logic                   irq_wdog,
  output logic                   chip_rst
);

  ////////////////////////////////////////////////////////////////////////////////
  // Reset synchroniser and timer tick.

  logic        rst_meta_reg;  // First stage, read only by the second.
  logic        rst_n;         // Synchronised reset used by the whole block.
  logic [1:0]  tick_cnt_reg;  // Divider from the system clock to the tick.
  logic        tick;          // One-cycle timer clock enable.

  // The release is synchronised so every counter leaves reset together.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // The 200 MHz clock divided by three stands in for the timer clock.
  assign tick = (tick_cnt_reg == 2'(`TMR_TICK_DIV - 1));

  // Free-running tick divider; it is not touched by the watchdog reset.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_reg <= 2'h0;
    end else if (tick) begin
      tick_cnt_reg <= 2'h0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // APB decode.

  logic        setup_ph;     // Setup phase of any transfer.
  logic        wr_acc;       // Write taking effect this cycle.
  logic        hit_ts;       // Address decodes.
  logic        hit_gp0rl;
  logic        hit_gp1rl;
  logic        hit_wdog;
  logic        hit_wen;
  logic        hit_key;
  logic        hit_sts;
  logic        mapped;       // Address names a register.
  logic        unlocked;     // Key holds the unlock value.
  logic        wr_wdog_ok;   // Accepted watchdog counter write.
  logic        wr_wen_ok;    // Accepted watchdog enable write.
  logic        srst;         // Block-wide reset caused by the watchdog.
  logic [15:0] key_reg;      // Watchdog protection key; declared here because the
                             // unlock compare below reads it.

  assign setup_ph  = psel & ~penable;
  assign wr_acc    = psel & penable & pwrite & ~srst;
  assign hit_ts    = (paddr == `TMR_OFF_TS);
  assign hit_gp0rl = (paddr == `TMR_OFF_GP0_RL);
  assign hit_gp1rl = (paddr == `TMR_OFF_GP1_RL);
  assign hit_wdog  = (paddr == `TMR_OFF_WDOG);
  assign hit_wen   = (paddr == `TMR_OFF_WDOG_EN);
  assign hit_key   = (paddr == `TMR_OFF_KEY);
  assign hit_sts   = (paddr == `TMR_OFF_STS);
  assign mapped    = hit_ts | hit_gp0rl | hit_gp1rl | hit_wdog | hit_wen | hit_key | hit_sts
                   | (paddr == `TMR_OFF_GP0) | (paddr == `TMR_OFF_GP1);
  assign unlocked   = (key_reg == `TMR_KEY_VALUE);
  assign wr_wdog_ok = wr_acc & hit_wdog & unlocked;
  assign wr_wen_ok  = wr_acc & hit_wen & unlocked;

  ////////////////////////////////////////////////////////////////////////////////
  // Registers.

  tmr_pkg::tmr_word_t ts_reg;       // Time-stamp up counter.
  tmr_pkg::tmr_word_t wdog_reg;     // Watchdog down counter.
  logic [2:0]         wen_reg;      // Watchdog count, irq and reset enables.
  tmr_pkg::tmr_sts_t  sts_reg;      // Sticky event flags.
  logic               wd_rst_reg;   // Watchdog-caused reset pulse.
  tmr_pkg::tmr_word_t gp0_cnt;      // Timer 0 count.
  tmr_pkg::tmr_word_t gp0_ctrl;     // Timer 0 reload readback.
  logic               gp0_fire;     // Timer 0 reached zero.
  tmr_pkg::tmr_word_t gp1_cnt;      // Timer 1 count.
  tmr_pkg::tmr_word_t gp1_ctrl;     // Timer 1 reload readback.
  logic               gp1_fire;     // Timer 1 reached zero.
  logic               ts_wrap;      // Time-stamp rolls over.
  logic               wd_zero;      // Watchdog decrements to zero.
  tmr_pkg::tmr_sts_t  sts_set;      // Hardware sets.
  tmr_pkg::tmr_sts_t  sts_clr;      // Software write-one clears.
  tmr_pkg::tmr_word_t rd_data;      // Read multiplexer.

  assign srst = wd_rst_reg;

  // Both timers are the same logic with their own write strobes.
  tmr_gp u_gp0 (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .srst    (srst),
    .tick    (tick),
    .wr_rl   (wr_acc & hit_gp0rl),
    .wdata   (pwdata),
    .cnt     (gp0_cnt),
    .ctrl    (gp0_ctrl),
    .fire    (gp0_fire)
  );

  tmr_gp u_gp1 (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .srst    (srst),
    .tick    (tick),
    .wr_rl   (wr_acc & hit_gp1rl),
    .wdata   (pwdata),
    .cnt     (gp1_cnt),
    .ctrl    (gp1_ctrl),
    .fire    (gp1_fire)
  );

  assign ts_wrap = tick & (ts_reg == 32'hFFFFFFFF);
  // A watchdog left at zero stays there instead of firing again.
  assign wd_zero = tick & wen_reg[`TMR_WEN_CNT] & (wdog_reg == 32'h00000001) & ~wr_wdog_ok;

  assign sts_set = {wd_zero & wen_reg[`TMR_WEN_RST],
                    wd_zero & wen_reg[`TMR_WEN_IRQ],
                    ts_wrap, gp1_fire, gp0_fire};
  assign sts_clr = (wr_acc & hit_sts) ? pwdata[4:0] : 5'h00;

  // Time-stamp: software may overwrite it, otherwise it counts and wraps.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ts_reg <= `TMR_ZERO32;
    end else if (srst) begin
      ts_reg <= `TMR_ZERO32;
    end else if (wr_acc && hit_ts) begin
      ts_reg <= pwdata;
    end else if (tick) begin
      ts_reg <= ts_reg + 32'h00000001;
    end
  end

  // Watchdog counter and enables, both guarded by the key.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wdog_reg <= `TMR_WDOG_RST;
      wen_reg  <= 3'h0;
      key_reg  <= 16'h0000;
    end else if (srst) begin
      wdog_reg <= `TMR_WDOG_RST;
      wen_reg  <= 3'h0;
      key_reg  <= 16'h0000;
    end else begin
      if (wr_acc && hit_key) begin
        key_reg <= pwdata[15:0];
      end
      if (wr_wen_ok) begin
        wen_reg <= pwdata[2:0];
      end
      if (wr_wdog_ok) begin
        wdog_reg <= pwdata;
      end else if (tick && wen_reg[`TMR_WEN_CNT] && wdog_reg != `TMR_ZERO32) begin
        wdog_reg <= wdog_reg - 32'h00000001;
      end
    end
  end

  // Status flags: a set in the clearing cycle survives. The warm bit is
  // kept through the watchdog reset so software can see why it restarted.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sts_reg    <= 5'h00;
      wd_rst_reg <= 1'b0;
    end else begin
      wd_rst_reg <= sts_set[`TMR_STS_WARM];
      if (srst) begin
        sts_reg <= {sts_reg[`TMR_STS_WARM], 4'h0};
      end else begin
        sts_reg <= (sts_reg & ~sts_clr) | sts_set;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // APB answer: zero wait states, data captured in the setup phase.

  // Reserved bits read as zero.
  always_comb begin
    rd_data = `TMR_ZERO32;
    case (paddr)
      `TMR_OFF_TS:      rd_data = ts_reg;
      `TMR_OFF_GP0:     rd_data = gp0_cnt;
      `TMR_OFF_GP0_RL:  rd_data = gp0_ctrl;
      `TMR_OFF_GP1:     rd_data = gp1_cnt;
      `TMR_OFF_GP1_RL:  rd_data = gp1_ctrl;
      `TMR_OFF_WDOG:    rd_data = wdog_reg;
      `TMR_OFF_WDOG_EN: rd_data = {29'h0, wen_reg};
      `TMR_OFF_KEY:     rd_data = {16'h0000, key_reg};
      `TMR_OFF_STS:     rd_data = {27'h0, sts_reg};
      default:          rd_data = `TMR_ZERO32;
    endcase
  end

  // Outputs come from flops; read data is frozen during the access phase.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prdata   <= `TMR_ZERO32;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      chip_rst <= 1'b0;
    end else begin
      pready   <= 1'b1;
      chip_rst <= sts_set[`TMR_STS_WARM];
      if (setup_ph) begin
        prdata  <= pwrite ? `TMR_ZERO32 : rd_data;
        pslverr <= ~mapped;
      end
    end
  end

  assign irq_gp0  = sts_reg[`TMR_STS_GP0];
  assign irq_gp1  = sts_reg[`TMR_STS_GP1];
  assign irq_ts   = sts_reg[`TMR_STS_TS];
  assign irq_wdog = sts_reg[`TMR_STS_WDOG];

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  // Each check is disabled while the synchronised reset is low, so the
  // first cycle after release only compares against reset values.

  AST_KEY_LOCK: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (psel && penable && pwrite && hit_wen && !unlocked && !srst) |=> $stable(wen_reg))
    else $error("Locked watchdog enable changed.");

  AST_WDOG_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!wen_reg[0] && !wr_wdog_ok && !srst) |=> $stable(wdog_reg))
    else $error("Disabled watchdog changed.");

  AST_WDOG_IRQ: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (wd_zero && wen_reg[1] && !wen_reg[2]) |=> irq_wdog)
    else $error("Watchdog zero raised no interrupt.");

  AST_WDOG_RST: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (wd_zero && wen_reg[2]) |=> (chip_rst && sts_reg[4]) ##1 (wen_reg == 3'h0 && wdog_reg == 32'hFFFFFFFF))
    else $error("Watchdog reset sequence wrong.");

  AST_WARM_KEEP: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (sts_reg[4] && !(wr_acc && hit_sts && pwdata[4])) |=> sts_reg[4])
    else $error("Warm bit lost.");

  AST_TS_WRAP: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ts_wrap && !srst && !(wr_acc && hit_ts)) |=> (ts_reg == 32'h00000000 && irq_ts))
    else $error("Time-stamp did not wrap.");

  AST_SET_WINS: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (gp0_fire && sts_clr[0] && !srst) |=> irq_gp0)
    else $error("Event lost against clear.");

  AST_TICK_RATE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tick |=> !tick ##1 !tick ##1 tick)
    else $error("Timer tick period wrong.");

  // Key writes are taken whatever the lock state.
  AST_KEY_ANY: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (wr_acc && hit_key) |=> (key_reg == $past(pwdata[15:0])))
    else $error("Key write was not taken.");

  // An unlocked counter write loads the whole word.
  AST_WDOG_LOAD: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr_wdog_ok |=> (wdog_reg == $past(pwdata)))
    else $error("Unlocked watchdog write lost.");

  // An enabled watchdog loses exactly one per tick until it sits at zero.
  AST_WDOG_DEC: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (tick && wen_reg[0] && wdog_reg != 32'h00000000 && !wr_wdog_ok && !srst)
    |=> (wdog_reg == $past(wdog_reg) - 32'h00000001))
    else $error("Watchdog did not decrement.");

  // With its interrupt masked the watchdog reaching zero stays silent.
  AST_WDOG_MASK: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (wd_zero && !wen_reg[1] && !irq_wdog) |=> !irq_wdog)
    else $error("Masked watchdog raised an interrupt.");

  // Writing one to the watchdog bit drops the interrupt unless a new event sets it.
  AST_WDOG_CLR: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (wr_acc && hit_sts && pwdata[3] && !sts_set[3]) |=> !irq_wdog)
    else $error("Watchdog interrupt not cleared.");

  // The chip reset request is a single-cycle pulse.
  AST_RST_PULSE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    chip_rst |=> !chip_rst)
    else $error("Chip reset request stuck high.");

  // The block-wide reset puts the timers and enables back to defaults.
  AST_SRST_DEFAULTS: assert property (@(posedge clk_sys) disable iff (!rst_n)
    srst |=> (wen_reg == 3'h0 && ts_reg == 32'h00000000 && gp0_ctrl == 32'h00000000
              && gp0_cnt == 32'h00000000 && gp1_ctrl == 32'h00000000 && gp1_cnt == 32'h00000000))
    else $error("Watchdog reset left state behind.");

  // Without a write the time-stamp moves by one per tick, wrapping naturally.
  AST_TS_COUNT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (tick && !srst && !(wr_acc && hit_ts)) |=> (ts_reg == $past(ts_reg) + 32'h00000001))
    else $error("Time-stamp did not count.");

  // Reserved status bits read back as zero.
  AST_STS_RESERVED: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (setup_ph && !pwrite && hit_sts) |=> (prdata[31:5] == 27'h0))
    else $error("Reserved status bits read non-zero.");

endmodule : tmr_top

//--- tmr_apb_master.sv
`timescale 1ns/100ps

// Processor-side model that issues one APB word transfer at a time.
module tmr_apb_master (
  input  wire logic               clk_sys,
  output logic                    psel,
  output logic                    penable,
  output logic                    pwrite,
  output logic [11:0]             paddr,
  output tmr_pkg::tmr_word_t      pwdata,
  input  wire tmr_pkg::tmr_word_t prdata,
  input  wire logic               pready,
  input  wire logic               pslverr
);
  // The bus idles with no request pending.
  initial begin
    {psel, penable, pwrite} = 3'h0;
    paddr                   = 12'h000;
    pwdata                  = 32'h00000000;
  end

  // Whole 32-bit words only; every field holds until pready is seen high.
  task automatic xfer(input logic wr, input logic [11:0] a, input tmr_pkg::tmr_word_t wd,
                      output tmr_pkg::tmr_word_t rd, output logic err);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    // No wait limit here: a slave that never answers is caught by the bench watchdog.
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released data must not look like a still-valid word.
    pwdata  <= ~wd;
  endtask : xfer
endmodule : tmr_apb_master

//--- tmr_top_bench.sv
`timescale 1ns/100ps
`include "tmr_consts.svh"

// Self-checking bench for the timer block.
module tmr_top_bench;
  logic               clk_sys;     // System clock.
  logic               nrst;        // Active-low system reset.
  logic               psel, penable, pwrite, pready, pslverr;
  logic [11:0]        paddr;       // Byte address.
  tmr_pkg::tmr_word_t pwdata;      // Write data.
  tmr_pkg::tmr_word_t prdata;      // Read data.
  logic               irq_gp0, irq_gp1, irq_ts, irq_wdog, chip_rst;
  logic [4:0]         evt;         // Event lines for polling.
  logic [15:0]        seed;        // Random generator state.
  int                 n_fail;      // Mismatch count.
  int                 comparisons; // Comparison count.
  tmr_pkg::tmr_word_t r, v, w, rl; // Scratch words.
  logic               pslverr_seen; // Error flag of the unmapped read.

  assign evt = {chip_rst, irq_wdog, irq_ts, irq_gp1, irq_gp0};

  tmr_top tmr_top_i (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq_gp0(irq_gp0), .irq_gp1(irq_gp1), .irq_ts(irq_ts),
    .irq_wdog(irq_wdog), .chip_rst(chip_rst));

  tmr_apb_master tmr_apb_master_i (.clk_sys(clk_sys), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Next state of a 16-bit Fibonacci shift register.
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  // Counter value a reload write must leave: reload field on top, two zero bits below.
  function automatic tmr_pkg::tmr_word_t gp_load(input tmr_pkg::tmr_word_t x);
    return {x[31:2], 2'b00};
  endfunction : gp_load

  // Draws a random word with both halves busy.
  task automatic draw(output tmr_pkg::tmr_word_t x);
    seed = lfsr(seed);
    x    = {seed, ~seed};
  endtask : draw

  // Compares and reports at once.
  task automatic chk(input string nm, input tmr_pkg::tmr_word_t e, input tmr_pkg::tmr_word_t g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic rd(input logic [11:0] a, output tmr_pkg::tmr_word_t x);
    logic e;
    tmr_apb_master_i.xfer(1'b0, a, 32'h00000000, x, e);
  endtask : rd

  task automatic wr(input logic [11:0] a, input tmr_pkg::tmr_word_t d);
    tmr_pkg::tmr_word_t x;
    logic e;
    tmr_apb_master_i.xfer(1'b1, a, d, x, e);
  endtask : wr

  task automatic rc(input logic [11:0] a, input tmr_pkg::tmr_word_t e);
    tmr_pkg::tmr_word_t x;
    rd(a, x);
    chk($sformatf("reg %h", a), e, x);
  endtask : rc

  // Polls an event line on the falling edge, where flop outputs are settled.
  task automatic wait_evt(input int b);
    int n;
    n = 0;
    while (evt[b] !== 1'b1 && n < 2000) begin
      @(negedge clk_sys);
      n++;
    end
    chk($sformatf("event line %0d", b), 32'h00000001, {31'h0, evt[b]});
  endtask : wait_evt

  task automatic print_verdict();
    if (n_fail == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard; the run needs well under 10000 cycles.
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  initial begin
    #200000;
    n_fail++;
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    nrst = 1'b0;
    seed = 16'h2DCF;
    n_fail = 0;
    comparisons = 0;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    // Defaults after reset.
    rc(`TMR_OFF_GP0, 32'h00000000);
    rc(`TMR_OFF_GP0_RL, 32'h00000000);
    rc(`TMR_OFF_GP1_RL, 32'h00000000);
    rc(`TMR_OFF_WDOG, `TMR_WDOG_RST);
    rc(`TMR_OFF_WDOG_EN, 32'h00000000);
    rc(`TMR_OFF_STS, 32'h00000000);
    rd(`TMR_OFF_TS, r);
    rd(`TMR_OFF_TS, v);
    chk("ts advances", 32'h00000001, {31'h0, v > r});
    // An unmapped word answers with an error and zero data.
    tmr_apb_master_i.xfer(1'b0, 12'h024, 32'h00000000, v, pslverr_seen);
    chk("unmapped error", 32'h00000001, {31'h0, pslverr_seen});
    chk("unmapped data", 32'h00000000, v);
    // Locked watchdog ignores writes, key is always writable.
    draw(r);
    wr(`TMR_OFF_WDOG, r);
    wr(`TMR_OFF_WDOG_EN, 32'h00000007);
    rc(`TMR_OFF_WDOG, `TMR_WDOG_RST);
    rc(`TMR_OFF_WDOG_EN, 32'h00000000);
    wr(`TMR_OFF_KEY, {16'hABCD, `TMR_KEY_VALUE});
    rc(`TMR_OFF_KEY, {16'h0000, `TMR_KEY_VALUE});
    wr(`TMR_OFF_WDOG, 32'h00000030);
    rc(`TMR_OFF_WDOG, 32'h00000030);
    wr(`TMR_OFF_WDOG_EN, 32'hFFFFFFF3);
    rc(`TMR_OFF_WDOG_EN, 32'h00000003);
    draw(r);
    wr(`TMR_OFF_KEY, (r[15:0] == `TMR_KEY_VALUE) ? 32'h00000000 : r);
    // Were this taken, the counter could not reach zero before the wait expires.
    wr(`TMR_OFF_WDOG, 32'hFFFFF000);
    wait_evt(3);
    rc(`TMR_OFF_WDOG, 32'h00000000);
    rc(`TMR_OFF_STS, 32'h00000008);
    wr(`TMR_OFF_STS, 32'h00000008);
    rc(`TMR_OFF_STS, 32'h00000000);
    chk("irq_wdog cleared", 32'h00000000, {31'h0, irq_wdog});
    // Counting with the interrupt masked raises nothing.
    wr(`TMR_OFF_KEY, {16'h0000, `TMR_KEY_VALUE});
    wr(`TMR_OFF_WDOG, 32'h00000008);
    wr(`TMR_OFF_WDOG_EN, 32'h00000001);
    repeat (60) @(posedge clk_sys);
    rc(`TMR_OFF_WDOG, 32'h00000000);
    chk("irq_wdog masked", 32'h00000000, {31'h0, irq_wdog});
    // Random reload values while disabled load exactly.
    for (int i = 0; i < 3; i++) begin
      draw(r);
      wr(`TMR_OFF_GP1_RL, r & 32'hFFFFFFFC);
      rc(`TMR_OFF_GP1, gp_load(r));
    end
    // Periodic timer 0.
    draw(r);
    rl = (r & 32'h000000FC) | 32'h00000101;
    wr(`TMR_OFF_GP0_RL, rl);
    rd(`TMR_OFF_GP0, v);
    w = gp_load(rl);
    chk("gp0 loaded", 32'h00000001, {31'h0, v == w || v == w - 32'h1});
    rc(`TMR_OFF_GP0_RL, rl);
    wait_evt(0);
    rd(`TMR_OFF_GP0, r);
    rd(`TMR_OFF_GP0, v);
    chk("gp0 keeps running", 32'h00000001, {31'h0, r != v});
    chk("irq_gp1 idle", 32'h00000000, {31'h0, irq_gp1});
    wr(`TMR_OFF_STS, 32'h00000001);
    wr(`TMR_OFF_GP0_RL, rl & 32'hFFFFFFFE);
    rc(`TMR_OFF_GP0, w);
    rc(`TMR_OFF_STS, 32'h00000000);
    // One-shot timer 1.
    wr(`TMR_OFF_GP1_RL, 32'h00000043);
    wait_evt(1);
    rc(`TMR_OFF_GP1_RL, 32'h00000042);
    rc(`TMR_OFF_GP1, 32'h00000040);
    rc(`TMR_OFF_STS, 32'h00000002);
    wr(`TMR_OFF_STS, 32'h00000002);
    // Time-stamp wrap.
    wr(`TMR_OFF_TS, 32'hFFFFFFF0);
    wait_evt(2);
    rd(`TMR_OFF_TS, v);
    chk("ts wrapped", 32'h00000001, {31'h0, v < 32'h00000100});
    rc(`TMR_OFF_STS, 32'h00000004);
    wr(`TMR_OFF_STS, 32'h00000004);
    rc(`TMR_OFF_STS, 32'h00000000);
    // Watchdog chip reset keeps only the warm bit; the first pass clears it by
    // writing one, the second by a system reset in mid-run.
    for (int k = 0; k < 2; k++) begin
      wr(`TMR_OFF_KEY, {16'h0000, `TMR_KEY_VALUE});
      wr(`TMR_OFF_WDOG, 32'h00000004);
      wr(`TMR_OFF_WDOG_EN, 32'h00000005);
      wait_evt(4);
      repeat (2) @(posedge clk_sys);
      rc(`TMR_OFF_STS, 32'h00000010);
      rc(`TMR_OFF_WDOG, `TMR_WDOG_RST);
      rc(`TMR_OFF_WDOG_EN, 32'h00000000);
      rc(`TMR_OFF_KEY, 32'h00000000);
      if (k == 0) begin
        wr(`TMR_OFF_STS, 32'h00000010);
      end else begin
        nrst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (3) @(posedge clk_sys);
      end
      rc(`TMR_OFF_STS, 32'h00000000);
    end
    print_verdict();
  end
endmodule : tmr_top_bench
